/* core/ncp_pkg.sv */
package ncp_pkg;

  // ******************************************************
  // register offsets
  // ******************************************************
  localparam logic [7:0] ADDR_COMMIT_PAGE = 8'h91;
  localparam logic [7:0] ADDR_POR_CTRL = 8'had;
  localparam logic [7:0] ADDR_CAP_HIGH = 8'hc7;
  localparam logic [7:0] ADDR_CAP_LOW = 8'hc8;

  // ******************************************************
  // fields and reset values
  // ******************************************************
  localparam int PAGE_W = 4;
  localparam logic [PAGE_W-1:0] COMMIT_PAGE_RST = 4'h0;
  localparam logic [PAGE_W-1:0] PAGE_MAX = 4'h5;
  localparam int PAGE_COUNT = 6;
  localparam int DEF_PAGE_W = 3;
  localparam int POR_SLOW1_BIT = 2;
  localparam int POR_SLOW2_BIT = 6;
  localparam logic POR_SLOW_RST = 1'b0;
  localparam int CAP_W = 10;
  localparam int CAP_HIGH_W = CAP_W - 8;
  localparam logic [7:0] REG_ZERO = 8'h00;

  // ******************************************************
  // nonvolatile map: common bytes first, then six pages
  // ******************************************************
  localparam int NVM_DEPTH = 345;
  localparam int NVM_AW = 9;
  localparam logic [NVM_AW-1:0] NVM_LOCKED_LAST = 9'h00a;
  localparam logic [NVM_AW-1:0] NVM_LAST = 9'h158;
  localparam logic [NVM_AW-1:0] NVM_COMMON_BYTES = 9'h027;
  localparam logic [NVM_AW-1:0] NVM_PAGE_BYTES = 9'h033;
  localparam logic [NVM_AW-1:0] NVM_POR_BYTE = 9'h025;
  localparam int NVM_SLOW1_POS = 1;
  localparam int NVM_SLOW2_POS = 5;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_LAST = 6'h32;
  localparam logic [IDX_W-1:0] IDX_ZERO = 6'h00;

  // ******************************************************
  // timing
  // ******************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int POR_SLOW_MS = 60;
  localparam int POR_SLOW_CYCLES = POR_SLOW_MS * (CLK_HZ / 1000);
  localparam int DLY_W = 23;
  localparam logic [DLY_W-1:0] DLY_ZERO = 23'h000000;
  localparam logic [DLY_W-1:0] DLY_ONE = 23'h000001;

  // ******************************************************
  // sequencer states
  // ******************************************************
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_FETCH = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN = 3'b011,
    ST_COMMIT = 3'b100,
    ST_MERGE = 3'b101,
    ST_SAVE = 3'b110
  } ncp_state_t;

endpackage : ncp_pkg

/* core/ncp_page_mem.sv */
`timescale 1ns/1ns
// ******************************************************
// nonvolatile/sram array, registered read, no reset
// ******************************************************
module ncp_page_mem (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [ncp_pkg::NVM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [ncp_pkg::NVM_DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } ncp_mem_state_t;

  ncp_mem_state_t s_q;
  ncp_mem_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rdata = s_q.mem[addr];
    if (we) begin
      s_d.mem[addr] = wdata;
    end
  end

  // contents survive rst, as stored bytes must
  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  assign rdata = s_q.rdata;

endmodule : ncp_page_mem

/* core/ncp_ctrl.sv */
`timescale 1ns/1ns
// Operation
// - A 4-bit commit page field picks the region a commit fills.
// - Six stored pages exist; two select pins pick the power-up page.
// - Slow power-on bits at bit 2 and bit 6; bit 2 resets to 0, stored.
// - A set slow power-on bit slows the internal power-on ramp only while both loop bandwidth bits are set.
// - Slow bits with loop bandwidth bits set add about 60 ms to power-on.
// - The 10-bit crystal load value reads back as bits 9..8 then 7..0.
// - The stored map holds common bytes first, then six page regions.
// - Stored bytes 0 to 10 refuse host writes; no commit or save step writes them.
module ncp_ctrl #(
  parameter int POR_SLOW_CYCLES = ncp_pkg::POR_SLOW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] page_sel_pins,
  input wire logic synth1_loop_bandwidth,
  input wire logic synth2_loop_bandwidth,
  input wire logic [ncp_pkg::CAP_W-1:0] crystal_load_cap_value,
  input wire logic register_commit_operation,
  output logic [ncp_pkg::IDX_W-1:0] cfg_rd_addr,
  input wire logic [7:0] cfg_rd_data,
  input wire logic nvm_wr,
  input wire logic nvm_rd,
  input wire logic [ncp_pkg::NVM_AW-1:0] nvm_addr,
  input wire logic [7:0] nvm_wdata,
  output logic [7:0] nvm_rdata,
  output logic nvm_wr_refused,
  output logic [ncp_pkg::DEF_PAGE_W-1:0] default_page,
  output logic commit_busy,
  output logic por_done,
  output logic por_slow_ramp,
  output logic synth1_slow_poweron,
  output logic synth2_slow_poweron
);

  localparam logic [ncp_pkg::DLY_W-1:0] DLY_LAST =
    ncp_pkg::DLY_W'(POR_SLOW_CYCLES - 1);

  typedef struct packed {
    ncp_pkg::ncp_state_t state;
    logic [ncp_pkg::PAGE_W-1:0] page;
    logic slow1;
    logic slow2;
    logic [ncp_pkg::IDX_W-1:0] idx;
    logic [ncp_pkg::DLY_W-1:0] dly;
    logic [7:0] rdata;
    logic refused;
    logic [ncp_pkg::DEF_PAGE_W-1:0] def_page;
  } ncp_ctrl_state_t;

  ncp_ctrl_state_t s_q;
  ncp_ctrl_state_t s_d;
  logic mem_we;
  logic [ncp_pkg::NVM_AW-1:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [ncp_pkg::NVM_AW-1:0] page_base;
  logic slow_active;
  logic host_wr_ok;

  // ******************************************************
  // derived terms
  // ******************************************************
  assign page_base = ncp_pkg::NVM_COMMON_BYTES
    + ncp_pkg::NVM_AW'(s_q.page * ncp_pkg::NVM_PAGE_BYTES);
  assign slow_active = (s_q.slow1 | s_q.slow2)
    & synth1_loop_bandwidth & synth2_loop_bandwidth;
  assign host_wr_ok = (nvm_addr > ncp_pkg::NVM_LOCKED_LAST)
    && (nvm_addr <= ncp_pkg::NVM_LAST);

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    s_d = s_q;
    s_d.refused = 1'b0;
    mem_we = 1'b0;
    mem_addr = nvm_addr;
    mem_wdata = nvm_wdata;
    unique case (s_q.state)
      ncp_pkg::ST_LOAD: begin
        mem_addr = ncp_pkg::NVM_POR_BYTE;
        s_d.def_page = {1'b0, page_sel_pins};
        s_d.state = ncp_pkg::ST_FETCH;
      end
      ncp_pkg::ST_FETCH: begin
        s_d.slow1 = mem_rdata[ncp_pkg::NVM_SLOW1_POS];
        s_d.slow2 = mem_rdata[ncp_pkg::NVM_SLOW2_POS];
        s_d.dly = ncp_pkg::DLY_ZERO;
        s_d.state = ncp_pkg::ST_DELAY;
      end
      ncp_pkg::ST_DELAY: begin
        if (!slow_active || s_q.dly == DLY_LAST) begin
          s_d.state = ncp_pkg::ST_RUN;
        end else begin
          s_d.dly = s_q.dly + ncp_pkg::DLY_ONE;
        end
        s_d.refused = nvm_wr;
      end
      ncp_pkg::ST_RUN: begin
        if (register_commit_operation && s_q.page <= ncp_pkg::PAGE_MAX) begin
          s_d.idx = ncp_pkg::IDX_ZERO;
          s_d.state = ncp_pkg::ST_COMMIT;
          s_d.refused = nvm_wr;
        end else if (nvm_wr) begin
          mem_we = host_wr_ok;
          s_d.refused = !host_wr_ok;
        end
      end
      ncp_pkg::ST_COMMIT: begin
        mem_we = 1'b1;
        mem_addr = page_base + ncp_pkg::NVM_AW'(s_q.idx);
        mem_wdata = cfg_rd_data;
        s_d.refused = nvm_wr;
        if (s_q.idx == ncp_pkg::IDX_LAST) begin
          s_d.state = ncp_pkg::ST_MERGE;
        end else begin
          s_d.idx = s_q.idx + 6'h01;
        end
      end
      ncp_pkg::ST_MERGE: begin
        mem_addr = ncp_pkg::NVM_POR_BYTE;
        s_d.refused = nvm_wr;
        s_d.state = ncp_pkg::ST_SAVE;
      end
      ncp_pkg::ST_SAVE: begin
        // keep reserved bits of the stored byte, refresh slow bits
        mem_we = 1'b1;
        mem_addr = ncp_pkg::NVM_POR_BYTE;
        mem_wdata = mem_rdata;
        mem_wdata[ncp_pkg::NVM_SLOW1_POS] = s_q.slow1;
        mem_wdata[ncp_pkg::NVM_SLOW2_POS] = s_q.slow2;
        s_d.refused = nvm_wr;
        s_d.state = ncp_pkg::ST_RUN;
      end
      default: begin
        s_d.state = ncp_pkg::ST_LOAD;
      end
    endcase

    // ****************************************************
    // register port
    // ****************************************************
    if (reg_wr && reg_addr == ncp_pkg::ADDR_COMMIT_PAGE) begin
      s_d.page = reg_wdata[ncp_pkg::PAGE_W-1:0];
    end
    if (reg_wr && reg_addr == ncp_pkg::ADDR_POR_CTRL) begin
      s_d.slow1 = reg_wdata[ncp_pkg::POR_SLOW1_BIT];
      s_d.slow2 = reg_wdata[ncp_pkg::POR_SLOW2_BIT];
    end
    if (reg_rd) begin
      s_d.rdata = ncp_pkg::REG_ZERO;
      unique case (reg_addr)
        ncp_pkg::ADDR_COMMIT_PAGE: begin
          s_d.rdata[ncp_pkg::PAGE_W-1:0] = s_q.page;
        end
        ncp_pkg::ADDR_POR_CTRL: begin
          s_d.rdata[ncp_pkg::POR_SLOW1_BIT] = s_q.slow1;
          s_d.rdata[ncp_pkg::POR_SLOW2_BIT] = s_q.slow2;
        end
        ncp_pkg::ADDR_CAP_HIGH: begin
          s_d.rdata[ncp_pkg::CAP_HIGH_W-1:0] =
            crystal_load_cap_value[ncp_pkg::CAP_W-1:8];
        end
        ncp_pkg::ADDR_CAP_LOW: begin
          s_d.rdata = crystal_load_cap_value[7:0];
        end
        default: begin
          s_d.rdata = ncp_pkg::REG_ZERO;
        end
      endcase
    end
  end

  // ******************************************************
  // state register
  // ******************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q.state <= ncp_pkg::ST_LOAD;
      s_q.page <= ncp_pkg::COMMIT_PAGE_RST;
      s_q.slow1 <= ncp_pkg::POR_SLOW_RST;
      s_q.slow2 <= ncp_pkg::POR_SLOW_RST;
      s_q.idx <= ncp_pkg::IDX_ZERO;
      s_q.dly <= ncp_pkg::DLY_ZERO;
      s_q.rdata <= ncp_pkg::REG_ZERO;
      s_q.refused <= 1'b0;
      s_q.def_page <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ncp_page_mem u_mem (
    .ref_clk(ref_clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ******************************************************
  // outputs
  // ******************************************************
  assign reg_rdata = s_q.rdata;
  assign nvm_rdata = mem_rdata;
  assign nvm_wr_refused = s_q.refused;
  assign default_page = s_q.def_page;
  assign cfg_rd_addr = s_q.idx;
  assign commit_busy = (s_q.state == ncp_pkg::ST_COMMIT)
    || (s_q.state == ncp_pkg::ST_MERGE) || (s_q.state == ncp_pkg::ST_SAVE);
  assign por_done = (s_q.state != ncp_pkg::ST_LOAD)
    && (s_q.state != ncp_pkg::ST_FETCH) && (s_q.state != ncp_pkg::ST_DELAY);
  assign por_slow_ramp = (s_q.state == ncp_pkg::ST_DELAY)
    && slow_active;
  assign synth1_slow_poweron = s_q.slow1;
  assign synth2_slow_poweron = s_q.slow2;

endmodule : ncp_ctrl

/* sim/ncp_cfg_src.sv */
`timescale 1ns/1ns
// ****************************************
// configuration byte source
// ****************************************
module ncp_cfg_src (
  input wire logic [ncp_pkg::IDX_W-1:0] cfg_rd_addr,
  output logic [7:0] cfg_rd_data
);
  // byte i of the live configuration, seen the same cycle
  assign cfg_rd_data = {cfg_rd_addr, 2'h1};
endmodule : ncp_cfg_src

/* sim/ncp_ctrl_asserts.sv */
`timescale 1ns/1ns
// ****************************************
// port checker
// ****************************************
module ncp_ctrl_asserts #(
  parameter int POR_SLOW_CYCLES = ncp_pkg::POR_SLOW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] page_sel_pins,
  input wire logic synth1_loop_bandwidth,
  input wire logic synth2_loop_bandwidth,
  input wire logic [ncp_pkg::CAP_W-1:0] crystal_load_cap_value,
  input wire logic [ncp_pkg::IDX_W-1:0] cfg_rd_addr,
  input wire logic nvm_wr,
  input wire logic [ncp_pkg::NVM_AW-1:0] nvm_addr,
  input wire logic nvm_wr_refused,
  input wire logic [ncp_pkg::DEF_PAGE_W-1:0] default_page,
  input wire logic commit_busy,
  input wire logic por_done,
  input wire logic por_slow_ramp,
  input wire logic synth1_slow_poweron,
  input wire logic synth2_slow_poweron
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff rst;
  logic [7:0] busy_cnt_q;
  logic [23:0] ramp_cnt_q;
  // lengths of the busy and slow ramp windows
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 8'h00;
      ramp_cnt_q <= 24'h000000;
    end else begin
      busy_cnt_q <= commit_busy ? busy_cnt_q + 8'h01 : 8'h00;
      ramp_cnt_q <= por_slow_ramp ? ramp_cnt_q + 24'h000001 : 24'h000000;
    end
  end
  property p_lock;
    nvm_wr && nvm_addr <= ncp_pkg::NVM_LOCKED_LAST && por_done
      |=> nvm_wr_refused;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked byte written");
  property p_busy_len;
    $fell(commit_busy) |-> busy_cnt_q == 8'h35;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("commit length");
  property p_walk;
    $rose(commit_busy) |-> cfg_rd_addr == 6'h00 ##50 cfg_rd_addr == 6'h32;
  endproperty
  a_walk: assert property (p_walk)
    else $error("commit index walk");
  property p_ramp_len;
    $fell(por_slow_ramp) |-> ramp_cnt_q == POR_SLOW_CYCLES && por_done;
  endproperty
  a_ramp_len: assert property (p_ramp_len)
    else $error("slow ramp length");
  property p_ramp_why;
    $rose(por_slow_ramp) |-> (synth1_slow_poweron | synth2_slow_poweron)
      && synth1_loop_bandwidth && synth2_loop_bandwidth;
  endproperty
  a_ramp_why: assert property (p_ramp_why)
    else $error("ramp cause");
  property p_page;
    $rose(por_done) |-> default_page == {1'b0, page_sel_pins};
  endproperty
  a_page: assert property (p_page) else $error("default page");
  property p_cap;
    reg_rd && reg_addr == 8'hc8 |=> reg_rdata == crystal_load_cap_value[7:0];
  endproperty
  a_cap: assert property (p_cap) else $error("load cap low byte");
  property p_por_rd;
    reg_rd && !reg_wr && reg_addr == 8'had |=> reg_rdata ==
      {1'b0, $past(synth2_slow_poweron), 3'h0,
      $past(synth1_slow_poweron), 2'h0};
  endproperty
  a_por_rd: assert property (p_por_rd)
    else $error("slow bits read");
endmodule : ncp_ctrl_asserts

bind ncp_ctrl ncp_ctrl_asserts #(.POR_SLOW_CYCLES(POR_SLOW_CYCLES)) u_chk (.*);

/* sim/nvm_page_commit_and_por_control_tb_top.sv */
`timescale 1ns/1ns
// ****************************************
// bench
// ****************************************
module nvm_page_commit_and_por_control_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic nvm_wr = 1'b0;
  logic nvm_rd = 1'b0;
  logic register_commit_operation = 1'b0;
  logic synth1_loop_bandwidth = 1'b1;
  logic synth2_loop_bandwidth = 1'b0;
  logic [1:0] page_sel_pins = 2'h2;
  logic [9:0] crystal_load_cap_value = 10'h2b7;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [8:0] nvm_addr = 9'h000;
  logic [7:0] nvm_wdata = 8'h00;
  logic [7:0] reg_rdata, nvm_rdata, cfg_rd_data;
  logic [5:0] cfg_rd_addr;
  logic [2:0] default_page;
  logic nvm_wr_refused, commit_busy, por_done, por_slow_ramp;
  logic synth1_slow_poweron, synth2_slow_poweron;
  logic [7:0] ra [4] = '{8'h91, 8'hc7, 8'hc8, 8'h50};
  logic [7:0] re [4] = '{8'h00, 8'h02, 8'hb7, 8'h00};
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  ncp_ctrl #(.POR_SLOW_CYCLES(20)) dut (.*);
  ncp_cfg_src u_cfg (.cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("reg_rdata", e, reg_rdata);
  endtask : rreg
  task automatic nwr(input logic [8:0] a, input logic [7:0] v, input logic r);
    @(negedge ref_clk);
    nvm_addr = a;
    nvm_wdata = v;
    nvm_wr = 1'b1;
    @(negedge ref_clk);
    nvm_wr = 1'b0;
    chk("nvm_wr_refused", {7'h00, r}, {7'h00, nvm_wr_refused});
  endtask : nwr
  task automatic nrd(input logic [8:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    nvm_addr = a;
    nvm_rd = 1'b1;
    @(negedge ref_clk);
    nvm_rd = 1'b0;
    chk("nvm_rdata", e, nvm_rdata);
  endtask : nrd
  task automatic cmt(input logic [7:0] e);
    int n;
    n = 0;
    @(negedge ref_clk);
    register_commit_operation = 1'b1;
    @(negedge ref_clk);
    register_commit_operation = 1'b0;
    while (commit_busy === 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk("busy_cycles", e, n[7:0]);
  endtask : cmt
  task automatic por_seq(input logic [7:0] e);
    int n;
    n = 0;
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (29) begin
      @(negedge ref_clk);
      n = n + int'(por_slow_ramp === 1'b1);
    end
    chk("ramp_cycles", e, n[7:0]);
    chk("por_done", 8'h01, {7'h00, por_done});
  endtask : por_seq
  initial begin
    por_seq(8'h00);
    wreg(8'hc8, 8'hff);
    wreg(8'h50, 8'hff);
    for (int i = 0; i < 4; i++) rreg(ra[i], re[i]);
    chk("default_page", 8'h02, {5'h00, default_page});
    wreg(8'h91, 8'hf3);
    rreg(8'h91, 8'h03);
    synth2_loop_bandwidth = 1'b1;
    wreg(8'had, 8'hff);
    rreg(8'had, 8'h44);
    chk("slow", 8'h03,
      {6'h00, synth2_slow_poweron, synth1_slow_poweron});
    nwr(9'h00a, 8'h5a, 1'b1);
    nwr(9'h159, 8'h5a, 1'b1);
    nwr(9'h00b, 8'ha5, 1'b0);
    nrd(9'h00b, 8'ha5);
    nwr(9'h025, 8'h00, 1'b0);
    cmt(8'h35);
    for (int i = 0; i < 51; i += 25) begin
      nrd(9'(192 + i), {i[5:0], 2'h1});
    end
    nrd(9'h025, 8'h22);
    wreg(8'h91, 8'h06);
    cmt(8'h00);
    wreg(8'h91, 8'h05);
    fork
      cmt(8'h35);
      begin
        repeat (3) @(negedge ref_clk);
        nwr(9'h00b, 8'h00, 1'b1);
      end
    join
    nrd(9'h126, 8'h01);
    nrd(9'h00b, 8'ha5);
    por_seq(8'h14);
    rreg(8'had, 8'h44);
    close_out();
  end
endmodule : nvm_page_commit_and_por_control_tb_top
